// [dpram_host_pkg.sv]
package dpram_host_pkg;
    // ==========================================================
    // geometry
    localparam int ADDR_W         = 15;
    localparam int DATA_W         = 9;
    localparam int SEM_COUNT      = 8;
    localparam int SEM_ADDR_W     = 3;
    localparam logic [14:0] MAILBOX_RIGHT = 15'h7fff;
    localparam logic [14:0] MAILBOX_LEFT  = 15'h7ffe;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SETUP_NS       = 20;
    localparam int PULSE_NS       = 20;
    localparam int FLOWTHROUGH_NS = 25;
    localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC      = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOW_CYC       = (FLOWTHROUGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_SETUP = 4'(SETUP_CYC);
    localparam logic [3:0] CNT_PULSE = 4'(PULSE_CYC);
    localparam logic [3:0] CNT_FLOW  = 4'(FLOW_CYC);
    // two more edges before the pin synchroniser agrees
    localparam logic [3:0] CNT_SYNC  = 4'h2;
    // ==========================================================
    // commands
    typedef enum logic [1:0] {
        CMD_READ     = 2'h0,
        CMD_WRITE    = 2'h1,
        CMD_SEM_GET  = 2'h2,
        CMD_SEM_FREE = 2'h3
    } cmd_e;

    typedef struct packed {
        cmd_e              cmd;
        logic [14:0]       addr;
        logic [8:0]        data;
        logic              frameByEnable;
    } req_s;

    typedef struct packed {
        logic              portSelect_n;
        logic              semaphoreSelect_n;
        logic              outputEnable_n;
        logic              readWrite;
        logic [14:0]       addr;
        logic [8:0]        dataOut;
        logic              dataOe;
    } pins_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_PULSE  = 3'h2,
        ST_WAIT   = 3'h3,
        ST_SAMPLE = 3'h4,
        ST_GAP    = 3'h5
    } state_e;
endpackage

// [pin_sync.sv]
module pin_sync
    import dpram_host_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // pins
    input  wire logic [W-1:0] pinIn,
    output logic [W-1:0]      pinStable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;
    sync_s st;
    sync_s next_st;

    // ==========================================================
    // three stages; change accepted when stage two and three agree
    always_comb begin
        next_st    = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{s1: '1, s2: '1, s3: '1, q: '1};
        end else begin
            st <= next_st;
        end
    end

    assign pinStable = st.q;
endmodule

// [dpram_port_host.sv]
module dpram_port_host
    import dpram_host_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int DATA_BITS = DATA_W
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // request side
    input  wire logic                 reqValid,
    input  wire req_s                 req,
    output logic                      reqReady,
    output logic                      rspValid,
    output logic [8:0]                rspData,
    output logic                      rspGranted,
    output logic                      rspBlocked,
    output logic                      mailIrq,
    // device pins
    output logic                      portSelect_n,
    output logic                      semaphoreSelect_n,
    output logic                      outputEnable_n,
    output logic                      readWrite,
    output logic [ADDR_BITS-1:0]      addr,
    output logic [DATA_BITS-1:0]      dataOut,
    output logic                      dataOe,
    input  wire logic [DATA_BITS-1:0] dataIn,
    input  wire logic                 busy_n,
    input  wire logic                 interrupt_n
);
    typedef struct packed {
        state_e      state;
        logic [3:0]  cnt;
        req_s        cur;
        pins_s       pins;
        logic        ready;
        logic        rspValid;
        logic [8:0]  rspData;
        logic        granted;
        logic        blocked;
        logic        busySeen;
        logic        irq;
        logic        semRead;
    } host_s;
    host_s st;
    host_s next_st;

    logic [DATA_BITS-1:0] dataSync;
    logic                 busySync_n;
    logic                 intSync_n;

    // ==========================================================
    // pin synchronisers
    pin_sync #(.W(DATA_BITS + 2)) u_sync (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .pinIn     ({dataIn, busy_n, interrupt_n}),
        .pinStable ({dataSync, busySync_n, intSync_n})
    );

    function automatic logic isSem(input cmd_e c);
        return (c == CMD_SEM_GET) || (c == CMD_SEM_FREE);
    endfunction

    function automatic logic isWrite(input cmd_e c);
        return (c != CMD_READ);
    endfunction

    // second pass of a semaphore request reads the latch back
    logic writing;
    assign writing = isWrite(st.cur.cmd) && !st.semRead;

    // ==========================================================
    // access sequencer
    always_comb begin
        next_st          = st;
        next_st.rspValid = 1'b0;
        next_st.irq      = ~intSync_n;
        case (st.state)
            ST_IDLE: begin
                next_st.ready = 1'b1;
                if (reqValid && st.ready) begin
                    next_st.ready    = 1'b0;
                    next_st.cur      = req;
                    next_st.busySeen = 1'b0;
                    next_st.semRead  = 1'b0;
                    // semaphore uses only three address bits and bit zero
                    next_st.pins.addr = isSem(req.cmd) ? {12'h000, req.addr[SEM_ADDR_W-1:0]} : req.addr;
                    next_st.pins.dataOut = (req.cmd == CMD_SEM_GET)  ? 9'h000 :
                                           (req.cmd == CMD_SEM_FREE) ? 9'h1ff : req.data;
                    next_st.pins.dataOe  = isWrite(req.cmd);
                    next_st.pins.readWrite = 1'b1;
                    next_st.pins.outputEnable_n = 1'b1;
                    next_st.cnt   = CNT_SETUP;
                    next_st.state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // select low; for every write the strobe falls in the same cycle
                if (isSem(st.cur.cmd)) begin
                    next_st.pins.semaphoreSelect_n = 1'b0;
                    next_st.pins.portSelect_n      = 1'b1;
                end else begin
                    next_st.pins.portSelect_n = 1'b0;
                end
                if (writing) begin
                    next_st.pins.readWrite = 1'b0;
                end else begin
                    next_st.pins.outputEnable_n = 1'b0;
                end
                next_st.cnt   = CNT_PULSE;
                next_st.state = ST_PULSE;
            end
            ST_PULSE: begin
                if (!busySync_n) begin
                    next_st.busySeen = 1'b1;
                end
                if (st.cnt > 4'h1) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else begin
                    next_st.cnt   = CNT_FLOW + CNT_SYNC;
                    next_st.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // reads wait out flowthrough plus sync latency
                if (writing || st.cnt <= 4'h1) begin
                    next_st.state = ST_SAMPLE;
                end else begin
                    next_st.cnt = st.cnt - 4'h1;
                end
            end
            ST_SAMPLE: begin
                if (!writing) begin
                    next_st.rspData = 9'(dataSync);
                    // reads drop the enable too, so it never stands without a select
                    next_st.pins.outputEnable_n = 1'b1;
                end
                next_st.granted = st.semRead && dataSync[0] == 1'b0;
                next_st.blocked = st.busySeen || !busySync_n;
                // end the cycle by the chosen control
                if (st.cur.frameByEnable) begin
                    next_st.pins.portSelect_n      = 1'b1;
                    next_st.pins.semaphoreSelect_n = 1'b1;
                end else begin
                    next_st.pins.readWrite      = 1'b1;
                    next_st.pins.outputEnable_n = 1'b1;
                end
                next_st.state = ST_GAP;
            end
            ST_GAP: begin
                // release everything; dropping select powers the port down
                next_st.pins.portSelect_n      = 1'b1;
                next_st.pins.semaphoreSelect_n = 1'b1;
                next_st.pins.readWrite         = 1'b1;
                next_st.pins.outputEnable_n    = 1'b1;
                next_st.pins.dataOe            = 1'b0;
                if (st.cur.cmd == CMD_SEM_GET && !st.semRead) begin
                    // one idle cycle with select high before the latch read
                    next_st.semRead = 1'b1;
                    next_st.cnt     = CNT_SETUP;
                    next_st.state   = ST_SETUP;
                end else begin
                    next_st.rspValid = 1'b1;
                    next_st.state    = ST_IDLE;
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{state: ST_IDLE, cnt: 4'h0, cur: '0,
                    pins: '{portSelect_n: 1'b1, semaphoreSelect_n: 1'b1, outputEnable_n: 1'b1,
                            readWrite: 1'b1, addr: 15'h0000, dataOut: 9'h000, dataOe: 1'b0},
                    ready: 1'b0, rspValid: 1'b0, rspData: 9'h000, granted: 1'b0,
                    blocked: 1'b0, busySeen: 1'b0, irq: 1'b0, semRead: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign reqReady          = st.ready;
    assign rspValid          = st.rspValid;
    assign rspData           = st.rspData;
    assign rspGranted        = st.granted;
    assign rspBlocked        = st.blocked;
    assign mailIrq           = st.irq;
    assign portSelect_n      = st.pins.portSelect_n;
    assign semaphoreSelect_n = st.pins.semaphoreSelect_n;
    assign outputEnable_n    = st.pins.outputEnable_n;
    assign readWrite         = st.pins.readWrite;
    assign addr              = st.pins.addr[ADDR_BITS-1:0];
    assign dataOut           = st.pins.dataOut[DATA_BITS-1:0];
    assign dataOe            = st.pins.dataOe;

    // ==========================================================
    // checks
    AST_SEM_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(st.pins.semaphoreSelect_n == 1'b0 && st.pins.portSelect_n == 1'b0))
        else $error("both selects low");
    AST_READ_NEEDS_SEL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!st.pins.outputEnable_n) |-> (!st.pins.portSelect_n || !st.pins.semaphoreSelect_n))
        else $error("output enable without select");
    AST_NO_DRIVE_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!st.pins.outputEnable_n) |-> !st.pins.dataOe)
        else $error("driving data during read");
    AST_SEM_BITS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st.state == ST_PULSE && st.cur.cmd == CMD_SEM_GET) |-> st.pins.dataOut[0] == 1'b0 && st.pins.addr[14:3] == 12'h000)
        else $error("semaphore request not zero");
    AST_WRITE_END: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st.state == ST_SAMPLE && isWrite(st.cur.cmd)) |=> (st.pins.readWrite || st.pins.portSelect_n && st.pins.semaphoreSelect_n))
        else $error("write not terminated");
    AST_RESP_TIME: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reqValid && reqReady && req.cmd == CMD_READ) |-> ##[5:12] rspValid)
        else $error("read answer out of window");
    AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rspValid |-> st.pins.portSelect_n && st.pins.semaphoreSelect_n)
        else $error("select held after access");
    AST_IRQ_FOLLOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(intSync_n) |=> mailIrq)
        else $error("mailbox interrupt not flagged");
endmodule

// [dpram_device_model.sv]
module dpram_device_model
    import dpram_host_pkg::*;
#(
    parameter int FLOW_NS = FLOWTHROUGH_NS
) (
    // left port, the host under test
    input  wire logic        portSelect_n,
    input  wire logic        semaphoreSelect_n,
    input  wire logic        outputEnable_n,
    input  wire logic        readWrite,
    input  wire logic [14:0] addr,
    input  wire logic [8:0]  dataOut,
    input  wire logic        dataOe,
    output logic [8:0]       dataIn,
    output logic             busy_n,
    output logic             interrupt_n,
    // right port, driven by the bench
    input  wire logic        rSel_n,
    input  wire logic        rSem_n,
    input  wire logic        rRw,
    input  wire logic [14:0] rAddr,
    input  wire logic [8:0]  rData,
    output logic             rInt_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // storage
    logic [8:0] mem [0:32767];
    logic [1:0] owner [0:7];
    logic [7:0] waitL;
    logic [7:0] waitR;
    logic [8:0] lastBus;
    logic       hit;
    logic       lDrive;
    wire  [8:0] arrOut;
    wire  [8:0] lOut;

    initial begin
        interrupt_n = 1'b1;
        rInt_n = 1'b1;
        waitL = 8'h00;
        waitR = 8'h00;
        lastBus = 9'h000;
        for (int i = 0; i < 8; i++) owner[i] = 2'h0;
    end

    // ==========================================================
    // flags and read path
    assign hit = !rSel_n && rAddr == addr;
    assign busy_n = !(hit && !portSelect_n);
    assign lDrive = !outputEnable_n && readWrite && (!portSelect_n || !semaphoreSelect_n);
    assign #(FLOW_NS) arrOut = mem[addr];
    assign lOut = !semaphoreSelect_n ? {9{owner[addr[2:0]] != 2'h1}} : arrOut;
    // a released bus must not keep its old value
    assign dataIn = lDrive ? lOut : (dataOe ? dataOut : ~lastBus);
    always @(lOut, dataOut, lDrive, dataOe) begin
        if (lDrive) lastBus = lOut;
        else if (dataOe) lastBus = dataOut;
    end

    // ==========================================================
    // semaphores
    task automatic semWrite(input logic [1:0] side, input logic [2:0] idx, input logic bit0);
        logic waiting;
        if (!bit0) begin
            if (side == 2'h1) waitL[idx] = 1'b1;
            else waitR[idx] = 1'b1;
            if (owner[idx] == 2'h0) owner[idx] = side;
        end else begin
            if (side == 2'h1) waitL[idx] = 1'b0;
            else waitR[idx] = 1'b0;
            waiting = (side == 2'h1) ? waitR[idx] : waitL[idx];
            if (owner[idx] == side) owner[idx] = waiting ? 2'h3 - side : 2'h0;
        end
    endtask

    // ==========================================================
    // writes land when either control ends the cycle
    always @(posedge (portSelect_n | readWrite)) begin
        if (!hit) begin
            mem[addr] = dataOut;
            if (addr == MAILBOX_RIGHT) rInt_n = 1'b0;
        end
    end
    always @(posedge (semaphoreSelect_n | readWrite)) semWrite(2'h1, addr[2:0], dataOut[0]);
    always @(posedge (rSel_n | rRw)) begin
        mem[rAddr] = rData;
        if (rAddr == MAILBOX_LEFT) interrupt_n = 1'b0;
    end
    always @(posedge (rSem_n | rRw)) semWrite(2'h2, rAddr[2:0], rData[0]);
    // busy keeps the left port from clearing its flag; the right port clears its flag regardless
    // contention taken from the match itself, so no race with the busy net
    always @* begin
        if (lDrive && !portSelect_n && !hit && addr == MAILBOX_LEFT) interrupt_n = 1'b1;
    end
    always @(rSel_n, rRw, rAddr) begin
        if (!rSel_n && rRw && rAddr == MAILBOX_RIGHT) rInt_n = 1'b1;
    end
endmodule

// [tb_top.sv]
module tb_top
    import dpram_host_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // signals
    logic        ref_clk, arst_n, reqValid, reqReady, rspValid, rspGranted, rspBlocked, mailIrq;
    req_s        req;
    logic        portSelect_n, semaphoreSelect_n, outputEnable_n, readWrite, dataOe, busy_n, interrupt_n;
    logic [14:0] addr, rAddr;
    logic [8:0]  rspData, dataOut, dataIn, rData;
    logic        rSel_n, rSem_n, rRw, rInt_n;
    int          errCount, samplesChecked;

    dpram_port_host u_dut (.ref_clk, .arst_n, .reqValid, .req, .reqReady, .rspValid, .rspData,
        .rspGranted, .rspBlocked, .mailIrq, .portSelect_n, .semaphoreSelect_n, .outputEnable_n,
        .readWrite, .addr, .dataOut, .dataOe, .dataIn, .busy_n, .interrupt_n);
    dpram_device_model u_model (.portSelect_n, .semaphoreSelect_n, .outputEnable_n, .readWrite,
        .addr, .dataOut, .dataOe, .dataIn, .busy_n, .interrupt_n, .rSel_n, .rSem_n, .rRw, .rAddr,
        .rData, .rInt_n);

    // ==========================================================
    // helpers
    task automatic check(input string what, input logic [8:0] expv, input logic [8:0] got);
        samplesChecked++;
        if (got !== expv) begin
            errCount++;
            $display("Error %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic access(input cmd_e c, input logic [14:0] a, input logic [8:0] d, input logic fbe);
        int n;
        n = 0;
        @(posedge ref_clk);
        reqValid <= 1'b1;
        req <= '{c, a, d, fbe};
        do @(posedge ref_clk); while (reqReady !== 1'b1 && ++n < 50);
        reqValid <= 1'b0;
        n = 0;
        do @(posedge ref_clk); while (rspValid !== 1'b1 && ++n < 20);
        check("answer", 9'h001, {8'h00, rspValid});
    endtask

    // right port write, framed by its read/write line
    task automatic rightWrite(input logic semaphore_select_n, input logic [14:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        rAddr <= a;
        rData <= d;
        rRw <= 1'b0;
        rSel_n <= semaphore_select_n;
        rSem_n <= !semaphore_select_n;
        repeat (2) @(posedge ref_clk);
        rRw <= 1'b1;
        @(posedge ref_clk);
        rSel_n <= 1'b1;
        rSem_n <= 1'b1;
        rData <= ~d;
    endtask

    // ==========================================================
    // scenarios
    task automatic testArray();
        access(CMD_WRITE, 15'h1234, 9'h1a5, 1'b0);
        access(CMD_WRITE, 15'h7ffd, 9'h1ff, 1'b1);
        check("word by rw", 9'h1a5, u_model.mem[15'h1234]);
        check("word by select", 9'h1ff, u_model.mem[15'h7ffd]);
        access(CMD_READ, 15'h1234, 9'h000, 1'b0);
        check("read back", 9'h1a5, rspData);
        access(CMD_READ, 15'h7ffd, 9'h000, 1'b1);
        check("read top bit", 9'h1ff, rspData);
        @(negedge ref_clk);
        check("idle controls", 9'h007, {6'h00, portSelect_n, semaphoreSelect_n, outputEnable_n});
    endtask

    task automatic testCross();
        rightWrite(1'b0, 15'h0100, 9'h0c3);
        access(CMD_READ, 15'h0100, 9'h000, 1'b0);
        check("cross-port read", 9'h0c3, rspData);
    endtask

    task automatic testMailbox();
        rightWrite(1'b0, MAILBOX_LEFT, 9'h011);
        repeat (8) @(posedge ref_clk);
        check("flag raised", 9'h001, {8'h00, mailIrq});
        @(posedge ref_clk);
        rAddr <= MAILBOX_LEFT;
        rSel_n <= 1'b0;
        access(CMD_READ, MAILBOX_LEFT, 9'h000, 1'b0);
        check("blocked", 9'h001, {8'h00, rspBlocked});
        rSel_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("flag kept", 9'h001, {8'h00, mailIrq});
        access(CMD_READ, MAILBOX_LEFT, 9'h000, 1'b0);
        check("mail word", 9'h011, rspData);
        check("not blocked", 9'h000, {8'h00, rspBlocked});
        repeat (8) @(posedge ref_clk);
        check("flag cleared", 9'h000, {8'h00, mailIrq});
        access(CMD_WRITE, MAILBOX_RIGHT, 9'h022, 1'b0);
        check("far flag", 9'h000, {8'h00, u_model.rInt_n});
    endtask

    task automatic testSemaphore();
        rightWrite(1'b1, 15'h0003, 9'h000);
        check("far owns", 9'h002, {7'h00, u_model.owner[3]});
        access(CMD_SEM_GET, 15'h0003, 9'h000, 1'b0);
        check("owner kept", 9'h002, {7'h00, u_model.owner[3]});
        check("refused", 9'h000, {8'h00, rspGranted});
        rightWrite(1'b1, 15'h0003, 9'h1ff);
        check("handed over", 9'h001, {7'h00, u_model.owner[3]});
        for (int i = 0; i < 8; i++) begin
            access(CMD_SEM_FREE, {12'h5a5, i[2:0]}, 9'h000, 1'b0);
            check("released", 9'h000, {7'h00, u_model.owner[i]});
            access(CMD_SEM_GET, {12'h5a5, i[2:0]}, 9'h000, 1'b0);
            check("claimed", 9'h001, {7'h00, u_model.owner[i]});
            check("granted", 9'h001, {8'h00, rspGranted});
        end
    endtask

    // ==========================================================
    // run control
    task automatic wrapUp();
        $display("Checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        errCount = 0;
        samplesChecked = 0;
        arst_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        rAddr = 15'h7ff0;
        rData = 9'h1ff;
        rRw = 1'b1;
        rSel_n = 1'b1;
        rSem_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        testArray();
        testCross();
        testMailbox();
        testSemaphore();
        wrapUp();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (4000) @(posedge ref_clk);
        errCount++;
        $display("Error watchdog expected finish seen hang");
        wrapUp();
    end
endmodule
